// >>> inc/sfr_pkg.sv
// Purpose: Shared constants and types for the serial flash register/read link.
// Assumes: One 25 MHz clock on both ends; link pins sampled as synchronous inputs.
// Notes: Host register offsets are byte addresses on the plain command port.
package sfr_pkg;
	// Opcodes.
	localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OP_WRITE_LOCK   = 8'h04;
	localparam logic [7:0] OP_ENTER_4B     = 8'hb7;
	localparam logic [7:0] OP_EXIT_4B      = 8'he9;
	localparam logic [7:0] OP_UPPER_WR     = 8'hc5;
	localparam logic [7:0] OP_UPPER_RD     = 8'hc8;
	localparam logic [7:0] OP_NVCFG_WR     = 8'hb1;
	localparam logic [7:0] OP_VCFG_WR      = 8'h81;
	localparam logic [7:0] OP_NVCFG_RD     = 8'hb5;
	localparam logic [7:0] OP_VCFG_RD      = 8'h85;
	localparam logic [7:0] OP_STAT_LO_RD   = 8'h05;
	localparam logic [7:0] OP_STAT_HI_RD   = 8'h35;
	localparam logic [7:0] OP_READ         = 8'h03;
	localparam logic [7:0] OP_READ_4B      = 8'h13;
	localparam logic [7:0] OP_FAST         = 8'h0b;
	localparam logic [7:0] OP_FAST_4B      = 8'h0c;
	localparam logic [7:0] OP_QOUT         = 8'h6b;
	localparam logic [7:0] OP_QOUT_4B      = 8'h6c;
	// Status bit positions.
	localparam int         ST_BUSY_BIT     = 0;
	localparam int         ST_WLATCH_BIT   = 1;
	localparam int         ST_FOUR_BIT     = 8;
	// Address and phase lengths in bits or clocks.
	localparam logic [5:0] ADDR3_BITS      = 6'h18;
	localparam logic [5:0] ADDR4_BITS      = 6'h20;
	localparam logic [5:0] BYTE_BITS       = 6'h08;
	localparam logic [5:0] FAST_DUMMY_CLKS = 6'h08;
	localparam logic [5:0] CFG_DUMMY_BITS  = 6'h08;
	// Reset values.
	localparam logic [7:0] UPPER_RST       = 8'h00;
	localparam logic [7:0] NVCFG_RST       = 8'hff;
	localparam logic [7:0] VCFG_RST        = 8'hff;
	// Register write time and its cycle count at the reference clock.
	localparam int         CLK_MHZ         = 25;
	localparam int         REG_WRITE_TIME_US = 10;
	localparam logic [15:0] REG_WRITE_CYC  = 16'(REG_WRITE_TIME_US * CLK_MHZ);
	localparam logic [15:0] VOL_WRITE_CYC  = 16'h0001;
	localparam int         MEM_AW          = 8;
	// Host serial clock half period in reference clocks.
	localparam logic [1:0] SCLK_HALF       = 2'h2;
	// Host command port map.
	localparam logic [7:0] REG_CTRL        = 8'h00;
	localparam logic [7:0] REG_ADDR        = 8'h04;
	localparam logic [7:0] REG_TXD         = 8'h08;
	localparam logic [7:0] REG_RXD         = 8'h0c;
	localparam logic [7:0] REG_STAT        = 8'h10;
	localparam int         CTRL_OP_LSB     = 0;
	localparam int         CTRL_ALEN_LSB   = 8;
	localparam int         CTRL_DUM_LSB    = 11;
	localparam int         CTRL_TX_BIT     = 16;
	localparam int         CTRL_QOUT_BIT   = 17;
	localparam int         CTRL_RXN_LSB    = 20;
	localparam int         CTRL_GO_BIT     = 31;
	localparam int         STAT_BUSY_BIT   = 0;
	localparam int         STAT_RXF_BIT    = 1;

	typedef enum logic [2:0] {
		DS_CMD   = 3'b000,
		DS_ADDR  = 3'b001,
		DS_DUMMY = 3'b010,
		DS_WDATA = 3'b011,
		DS_ARM   = 3'b100,
		DS_OUT   = 3'b101,
		DS_SKIP  = 3'b110
	} sfr_dst_t;

	typedef enum logic [2:0] {
		HS_IDLE  = 3'b000,
		HS_CMD   = 3'b001,
		HS_ADDR  = 3'b010,
		HS_DUMMY = 3'b011,
		HS_TX    = 3'b100,
		HS_RX    = 3'b101,
		HS_RXW   = 3'b110,
		HS_END   = 3'b111
	} sfr_hst_t;
endpackage

// >>> inc/sfr_link_if.sv
// Purpose: Serial link between host controller and flash device.
// Assumes: Undriven data lines read high, as with pull-ups.
// Notes: Each data line is resolved here from both ends' enables.
`timescale 1ns/1ps
interface sfr_link_if;
	logic       cs_n;
	logic       sclk;
	logic [3:0] h_io_o;
	logic [3:0] h_io_oe;
	logic [3:0] d_io_o;
	logic [3:0] d_io_oe;
	logic [3:0] io_i;

	for (genvar i = 0; i < 4; i++) begin : g_line
		assign io_i[i] = d_io_oe[i] ? d_io_o[i] : (h_io_oe[i] ? h_io_o[i] : 1'b1);
	end

	modport dev (input cs_n, input sclk, input io_i, output d_io_o, output d_io_oe);
	modport host (output cs_n, output sclk, output h_io_o, output h_io_oe, input io_i);
endinterface

// >>> rtl/sfr_mem.sv
// Purpose: Byte array behind the device's read commands.
// Assumes: Loaded from the user side; contents are not reset.
// Notes: Read is combinational so a byte is ready at each reload.
`timescale 1ns/1ps
module sfr_mem
	import sfr_pkg::*;
(
	input  wire logic              i_ref_clk,
	input  wire logic              i_we,
	input  wire logic [MEM_AW-1:0] i_waddr,
	input  wire logic [7:0]        i_wdata,
	input  wire logic [MEM_AW-1:0] i_raddr,
	output logic      [7:0]        o_rdata
);
	logic [7:0] mem [0:(1<<MEM_AW)-1];

	always_ff @(posedge i_ref_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	assign o_rdata = mem[i_raddr];
endmodule // sfr_mem

// >>> rtl/sfr_dev.sv
// Purpose: Flash device end: register commands and single, fast and quad reads.
// Assumes: Host clock edges are at least two reference clocks apart.
// Notes: Configuration registers are one byte each; the address selects nothing.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
module sfr_dev
	import sfr_pkg::*;
(
	input  wire logic              i_ref_clk,
	input  wire logic              i_srst,
	input  wire logic              i_quad_mode,
	input  wire logic              i_load_we,
	input  wire logic [MEM_AW-1:0] i_load_addr,
	input  wire logic [7:0]        i_load_data,
	output logic                   o_busy,
	sfr_link_if.dev                lnk
);
	sfr_dst_t          state_r;
	logic              sclk_q_r;
	logic              cs_q_r;
	logic [7:0]        op_r;
	logic [31:0]       sh_r;
	logic [5:0]        cnt_r;
	logic [31:0]       addr_r;
	logic [7:0]        data_r;
	logic [7:0]        out_sh_r;
	logic [5:0]        out_cnt_r;
	logic [3:0]        dout_r;
	logic [3:0]        oe_r;
	logic              wlatch_r;
	logic              busy_r;
	logic              four_r;
	logic [7:0]        upper_r;
	logic [7:0]        nvcfg_r;
	logic [7:0]        vcfg_r;
	logic [15:0]       tmr_r;
	logic              pend_nv_r;
	logic [7:0]        pend_d_r;
	logic              rise;
	logic              fall;
	logic              cs_rise;
	logic              exec;
	logic [5:0]        w_in;
	logic [5:0]        w_out;
	logic              qout;
	logic [31:0]       sh_nxt;
	logic [5:0]        cnt_nxt;
	logic              wide4;
	logic [5:0]        alen;
	logic [31:0]       eff_addr;
	logic [7:0]        op_in;
	sfr_dst_t          cmd_dst;
	logic [5:0]        dum_n;
	logic [15:0]       stat;
	logic [MEM_AW-1:0] rd_addr;
	logic [7:0]        mem_q;

	assign rise    = lnk.sclk & ~sclk_q_r;
	assign fall    = ~lnk.sclk & sclk_q_r;
	assign cs_rise = lnk.cs_n & ~cs_q_r;
	assign exec    = cs_rise & (state_r == DS_ARM);
	assign w_in    = i_quad_mode ? 6'h04 : 6'h01;
	assign qout    = i_quad_mode | (op_r == OP_QOUT) | (op_r == OP_QOUT_4B);
	assign w_out   = qout ? 6'h04 : 6'h01;
	assign sh_nxt  = i_quad_mode ? {sh_r[27:0], lnk.io_i} : {sh_r[30:0], lnk.io_i[0]};
	assign cnt_nxt = cnt_r + w_in;
	assign op_in   = sh_nxt[7:0];
	assign wide4   = (op_r == OP_READ_4B) | (op_r == OP_FAST_4B) | (op_r == OP_QOUT_4B);
	assign alen    = (four_r | wide4) ? ADDR4_BITS : ADDR3_BITS;
	// In three-byte mode with a non-4B opcode the upper register supplies bits 31 to 24.
	assign eff_addr = (alen == ADDR4_BITS) ? sh_nxt : {upper_r, sh_nxt[23:0]};
	assign dum_n   = ((op_r == OP_NVCFG_RD) | (op_r == OP_VCFG_RD))
		? (i_quad_mode ? (CFG_DUMMY_BITS >> 2) : CFG_DUMMY_BITS) : FAST_DUMMY_CLKS;
	assign stat    = 16'((16'(four_r) << ST_FOUR_BIT) | (16'(wlatch_r) << ST_WLATCH_BIT)
		| (16'(busy_r) << ST_BUSY_BIT));
	assign rd_addr = (state_r == DS_ADDR) ? eff_addr[MEM_AW-1:0]
		: (state_r == DS_DUMMY) ? addr_r[MEM_AW-1:0] : MEM_AW'(addr_r[MEM_AW-1:0] + 1'b1);
	assign o_busy      = busy_r;
	assign lnk.d_io_o  = dout_r;
	assign lnk.d_io_oe = oe_r;

	sfr_mem u_mem (
		.i_ref_clk (i_ref_clk),
		.i_we      (i_load_we),
		.i_waddr   (i_load_addr),
		.i_wdata   (i_load_data),
		.i_raddr   (rd_addr),
		.o_rdata   (mem_q)
	);

	function automatic logic [7:0] src_byte(input logic [7:0] op, input logic [7:0] mq);
		case (op)
			OP_STAT_LO_RD: src_byte = stat[7:0];
			OP_STAT_HI_RD: src_byte = stat[15:8];
			OP_UPPER_RD:   src_byte = upper_r;
			OP_NVCFG_RD:   src_byte = nvcfg_r;
			OP_VCFG_RD:    src_byte = vcfg_r;
			default:       src_byte = mq;
		endcase
	endfunction

	// Busy rejects everything but status reads.
	always_comb begin
		case (op_in)
			OP_STAT_LO_RD, OP_STAT_HI_RD: cmd_dst = DS_OUT;
			OP_UPPER_RD: cmd_dst = busy_r ? DS_SKIP : DS_OUT;
			OP_WRITE_UNLOCK, OP_WRITE_LOCK, OP_ENTER_4B, OP_EXIT_4B: cmd_dst = busy_r ? DS_SKIP : DS_ARM;
			OP_UPPER_WR: cmd_dst = (busy_r | ~wlatch_r) ? DS_SKIP : DS_WDATA;
			OP_NVCFG_WR, OP_VCFG_WR: cmd_dst = (busy_r | ~wlatch_r) ? DS_SKIP : DS_ADDR;
			OP_NVCFG_RD, OP_VCFG_RD, OP_READ, OP_READ_4B, OP_FAST, OP_FAST_4B, OP_QOUT, OP_QOUT_4B:
				cmd_dst = busy_r ? DS_SKIP : DS_ADDR;
			default: cmd_dst = DS_SKIP;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			sclk_q_r <= 1'b0;
			cs_q_r   <= 1'b1;
		end else begin
			sclk_q_r <= lnk.sclk;
			cs_q_r   <= lnk.cs_n;
		end
	end

	// Frame sequencing, shifting in on rising and out on falling host edges.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || lnk.cs_n) begin
			state_r   <= DS_CMD;
			cnt_r     <= 6'h00;
			dout_r    <= 4'h0;
			oe_r      <= 4'h0;
			out_cnt_r <= 6'h00;
			if (i_srst) begin
				op_r     <= 8'h00;
				sh_r     <= 32'h0;
				addr_r   <= 32'h0;
				data_r   <= 8'h00;
				out_sh_r <= 8'h00;
			end
		end else if (rise) begin
			case (state_r)
				DS_CMD: begin
					sh_r  <= sh_nxt;
					cnt_r <= cnt_nxt;
					if (cnt_nxt == BYTE_BITS) begin
						op_r     <= op_in;
						cnt_r    <= 6'h00;
						state_r  <= cmd_dst;
						out_sh_r <= src_byte(op_in, mem_q);
					end
				end
				DS_ADDR: begin
					sh_r  <= sh_nxt;
					cnt_r <= cnt_nxt;
					if (cnt_nxt == alen) begin
						addr_r <= eff_addr;
						cnt_r  <= 6'h00;
						if ((op_r == OP_NVCFG_WR) || (op_r == OP_VCFG_WR)) begin
							state_r <= DS_WDATA;
						end else if ((op_r == OP_READ) || (op_r == OP_READ_4B)) begin
							state_r  <= DS_OUT;
							out_sh_r <= mem_q;
						end else begin
							state_r <= DS_DUMMY;
						end
					end
				end
				DS_DUMMY: begin
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r + 6'h01 == dum_n) begin
						state_r  <= DS_OUT;
						out_sh_r <= src_byte(op_r, mem_q);
					end
				end
				DS_WDATA: begin
					sh_r  <= sh_nxt;
					cnt_r <= cnt_nxt;
					if (cnt_nxt == BYTE_BITS) begin
						data_r  <= sh_nxt[7:0];
						state_r <= DS_ARM;
					end
				end
				DS_ARM: state_r <= DS_SKIP;
				DS_OUT, DS_SKIP: state_r <= state_r;
				default: state_r <= DS_SKIP;
			endcase
		end else if (fall && (state_r == DS_OUT)) begin
			dout_r <= qout ? out_sh_r[7:4] : {2'b00, out_sh_r[7], 1'b0};
			oe_r   <= qout ? 4'hf : 4'h2;
			if (out_cnt_r + w_out == BYTE_BITS) begin
				out_cnt_r <= 6'h00;
				out_sh_r  <= src_byte(op_r, mem_q);
				addr_r    <= addr_r + 32'h1;
			end else begin
				out_cnt_r <= out_cnt_r + w_out;
				out_sh_r  <= qout ? {out_sh_r[3:0], 4'h0} : {out_sh_r[6:0], 1'b0};
			end
		end
	end

	// Write latch, address mode and upper address register.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			wlatch_r <= 1'b0;
			four_r   <= 1'b0;
			upper_r  <= UPPER_RST;
		end else if (exec) begin
			case (op_r)
				OP_WRITE_UNLOCK: wlatch_r <= 1'b1;
				OP_WRITE_LOCK:   wlatch_r <= 1'b0;
				OP_ENTER_4B:     four_r <= 1'b1;
				OP_EXIT_4B:      four_r <= 1'b0;
				OP_UPPER_WR: begin
					upper_r  <= data_r;
					wlatch_r <= 1'b0;
				end
				default: wlatch_r <= wlatch_r;
			endcase
		end else if (busy_r && (tmr_r == 16'h0001)) begin
			wlatch_r <= 1'b0;
		end else if (rise && (state_r == DS_ADDR) && (cnt_nxt == alen) && four_r) begin
			upper_r <= sh_nxt[31:24];
		end
	end

	// Self-timed configuration write.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			busy_r    <= 1'b0;
			tmr_r     <= 16'h0000;
			pend_nv_r <= 1'b0;
			pend_d_r  <= 8'h00;
			nvcfg_r   <= NVCFG_RST;
			vcfg_r    <= VCFG_RST;
		end else if (exec && ((op_r == OP_NVCFG_WR) || (op_r == OP_VCFG_WR))) begin
			busy_r    <= 1'b1;
			pend_nv_r <= (op_r == OP_NVCFG_WR);
			pend_d_r  <= data_r;
			tmr_r     <= (op_r == OP_NVCFG_WR) ? REG_WRITE_CYC : VOL_WRITE_CYC;
			if (op_r == OP_VCFG_WR) begin
				vcfg_r <= data_r;
			end
		end else if (busy_r) begin
			tmr_r <= tmr_r - 16'h0001;
			if (tmr_r == 16'h0001) begin
				busy_r <= 1'b0;
				if (pend_nv_r) begin
					nvcfg_r <= pend_d_r;
				end
			end
		end
	end
endmodule // sfr_dev

// >>> rtl/sfr_host.sv
// Purpose: Host controller end: runs one framed command per software order.
// Assumes: Software sets phase lengths to match the device's address mode.
// Notes: Each received byte but the last stalls the clock until software reads it.
`timescale 1ns/1ps
module sfr_host
	import sfr_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_srst,
	input  wire logic        i_quad_mode,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	sfr_link_if.host         lnk
);
	sfr_hst_t    state_r;
	sfr_hst_t    ph_nxt;
	logic [31:0] ctrl_r;
	logic [31:0] addr_r;
	logic [7:0]  txd_r;
	logic [7:0]  rxd_r;
	logic        rxf_r;
	logic [7:0]  rxn_r;
	logic [31:0] tx_sh_r;
	logic [7:0]  rx_sh_r;
	logic [5:0]  ccnt_r;
	logic [1:0]  div_r;
	logic        sclk_r;
	logic        cs_n_r;
	logic [31:0] rdata_r;
	logic [2:0]  alen;
	logic [5:0]  byte_clks;
	logic        qrx;
	logic        tick;
	logic        go;

	assign alen      = ctrl_r[CTRL_ALEN_LSB +: 3];
	assign byte_clks = i_quad_mode ? 6'h02 : 6'h08;
	assign qrx       = i_quad_mode | ctrl_r[CTRL_QOUT_BIT];
	assign tick      = (div_r == SCLK_HALF - 2'h1);
	assign go        = i_wr && (i_addr == REG_CTRL) && i_wdata[CTRL_GO_BIT] && (state_r == HS_IDLE);
	assign lnk.cs_n  = cs_n_r;
	assign lnk.sclk  = sclk_r;
	assign lnk.h_io_o = i_quad_mode ? tx_sh_r[31:28] : {3'b000, tx_sh_r[31]};
	assign lnk.h_io_oe = (state_r inside {HS_CMD, HS_ADDR, HS_TX}) ? (i_quad_mode ? 4'hf : 4'h1) : 4'h0;
	assign o_rdata   = rdata_r;

	// Phase order: command, address, dummy, write byte, read bytes.
	always_comb begin
		if ((state_r == HS_CMD) && (alen != 3'h0)) begin
			ph_nxt = HS_ADDR;
		end else if ((state_r inside {HS_CMD, HS_ADDR}) && (ctrl_r[CTRL_DUM_LSB +: 5] != 5'h00)) begin
			ph_nxt = HS_DUMMY;
		end else if ((state_r inside {HS_CMD, HS_ADDR, HS_DUMMY}) && ctrl_r[CTRL_TX_BIT]) begin
			ph_nxt = HS_TX;
		end else if ((state_r inside {HS_CMD, HS_ADDR, HS_DUMMY, HS_TX}) && (rxn_r != 8'h00)) begin
			ph_nxt = HS_RX;
		end else begin
			ph_nxt = HS_END;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst || (state_r == HS_IDLE) || (state_r == HS_RXW)) begin
			div_r <= 2'h0;
		end else begin
			div_r <= tick ? 2'h0 : div_r + 2'h1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			state_r <= HS_IDLE;
			cs_n_r  <= 1'b1;
			sclk_r  <= 1'b0;
			tx_sh_r <= 32'h0;
			rx_sh_r <= 8'h00;
			ccnt_r  <= 6'h00;
			rxn_r   <= 8'h00;
		end else if (go) begin
			state_r <= HS_CMD;
			cs_n_r  <= 1'b0;
			tx_sh_r <= {i_wdata[CTRL_OP_LSB +: 8], 24'h0};
			ccnt_r  <= byte_clks;
			rxn_r   <= i_wdata[CTRL_RXN_LSB +: 8];
		end else if ((state_r == HS_RXW) && !rxf_r) begin
			state_r <= HS_RX;
		end else if (tick && (state_r == HS_END)) begin
			cs_n_r  <= 1'b1;
			state_r <= HS_IDLE;
		end else if (tick && (state_r != HS_IDLE) && (state_r != HS_RXW)) begin
			if (!sclk_r) begin
				sclk_r <= 1'b1;
				if (state_r == HS_RX) begin
					rx_sh_r <= qrx ? {rx_sh_r[3:0], lnk.io_i} : {rx_sh_r[6:0], lnk.io_i[1]};
				end
			end else begin
				sclk_r <= 1'b0;
				if (ccnt_r != 6'h01) begin
					ccnt_r  <= ccnt_r - 6'h01;
					tx_sh_r <= i_quad_mode ? {tx_sh_r[27:0], 4'h0} : {tx_sh_r[30:0], 1'b0};
				end else if (state_r == HS_RX) begin
					rxn_r   <= rxn_r - 8'h01;
					ccnt_r  <= qrx ? 6'h02 : 6'h08;
					state_r <= (rxn_r == 8'h01) ? HS_END : HS_RXW;
				end else begin
					state_r <= ph_nxt;
					case (ph_nxt)
						HS_ADDR: begin
							tx_sh_r <= (alen == 3'h4) ? addr_r : {addr_r[23:0], 8'h00};
							ccnt_r  <= i_quad_mode ? 6'({alen, 1'b0}) : 6'({alen, 3'b000});
						end
						HS_DUMMY: ccnt_r <= {1'b0, ctrl_r[CTRL_DUM_LSB +: 5]};
						HS_TX: begin
							tx_sh_r <= {txd_r, 24'h0};
							ccnt_r  <= byte_clks;
						end
						HS_RX: ccnt_r <= qrx ? 6'h02 : 6'h08;
						default: ccnt_r <= 6'h00;
					endcase
				end
			end
		end
	end

	// Received byte flag: a new byte wins over a clearing read.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			rxd_r <= 8'h00;
			rxf_r <= 1'b0;
		end else if (tick && sclk_r && (state_r == HS_RX) && (ccnt_r == 6'h01)) begin
			rxd_r <= rx_sh_r;
			rxf_r <= 1'b1;
		end else if (i_rd && (i_addr == REG_RXD)) begin
			rxf_r <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			ctrl_r <= 32'h0;
			addr_r <= 32'h0;
			txd_r  <= 8'h00;
		end else if (i_wr && (state_r == HS_IDLE)) begin
			case (i_addr)
				REG_CTRL: ctrl_r <= {1'b0, i_wdata[30:0]};
				REG_ADDR: addr_r <= i_wdata;
				REG_TXD:  txd_r  <= i_wdata[7:0];
				default:  txd_r  <= txd_r;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst || !i_rd) begin
			rdata_r <= 32'h0;
		end else begin
			case (i_addr)
				REG_CTRL: rdata_r <= ctrl_r;
				REG_ADDR: rdata_r <= addr_r;
				REG_TXD:  rdata_r <= {24'h0, txd_r};
				REG_RXD:  rdata_r <= {24'h0, rxd_r};
				REG_STAT: rdata_r <= 32'((32'(rxf_r) << STAT_RXF_BIT) | (32'(state_r != HS_IDLE) << STAT_BUSY_BIT));
				default:  rdata_r <= 32'h0;
			endcase
		end
	end
endmodule // sfr_host

// >>> dv/sfr_link_chk.sv
// Purpose: Concurrent checks on the link between host and device ends.
// Assumes: One clock domain; reset is synchronous and active high.
// Notes: Sees only the interface lines, the clock, the reset and the mode pin.
`timescale 1ns/1ps
module sfr_link_chk (
	input  wire logic       i_ref_clk,
	input  wire logic       i_srst,
	input  wire logic       i_quad_mode,
	input  wire logic       cs_n,
	input  wire logic       sclk,
	input  wire logic [3:0] h_io_oe,
	input  wire logic [3:0] d_io_oe
);
	logic [5:0] rise_cnt_r;
	logic       sclk_d_r;

	// Counts serial clock rises inside the current frame, saturating.
	always_ff @(posedge i_ref_clk) begin
		sclk_d_r <= sclk;
		if (i_srst || cs_n) begin
			rise_cnt_r <= 6'h00;
		end else if (sclk && !sclk_d_r && rise_cnt_r != 6'h3f) begin
			rise_cnt_r <= rise_cnt_r + 6'h01;
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);

	cs_idle_a: assert property (cs_n |-> !sclk)
		else $error("serial clock high outside a frame");
	frame_start_a: assert property ($fell(cs_n) |-> !sclk [*2] ##1 sclk)
		else $error("first serial clock rise mistimed");
	sclk_high_a: assert property ($rose(sclk) |=> sclk ##1 !sclk)
		else $error("serial clock high phase not two cycles");
	dev_quiet_a: assert property (cs_n [*3] |-> d_io_oe == 4'h0)
		else $error("device drives lines while deselected");
	dev_late_a: assert property (!cs_n && d_io_oe != 4'h0 |-> rise_cnt_r >= (i_quad_mode ? 6'h02 : 6'h08))
		else $error("device drives before the opcode is in");
	no_fight_a: assert property ((h_io_oe & d_io_oe) == 4'h0)
		else $error("both ends drive one line");
	host_single_a: assert property (!i_quad_mode |-> h_io_oe[3:1] == 3'h0)
		else $error("host drives a quad line in single mode");
	dev_lines_a: assert property (d_io_oe inside {4'h0, 4'h2, 4'hf})
		else $error("device enables not a legal line set");
	quad_lines_a: assert property (i_quad_mode |-> d_io_oe != 4'h2)
		else $error("device uses one line in quad command mode");
endmodule // sfr_link_chk

// >>> dv/serial_flash_reg_and_read_cmds_bench.sv
// Purpose: Self-checking bench joining the host and device ends.
// Assumes: Both ends share the clock and the quad command mode setting.
// Notes: Received bytes are compared against a queue filled by the driver.
`timescale 1ns/1ps
module serial_flash_reg_and_read_cmds_bench;
	import sfr_pkg::*;
	logic              i_ref_clk, i_srst, i_quad_mode, i_load_we, i_wr, i_rd, o_busy, rxd_p, sclk_d;
	logic [MEM_AW-1:0] i_load_addr;
	logic [7:0]        i_load_data, i_addr, rx_sh, r, u;
	logic [7:0]        mem_m [256];
	logic [7:0]        exp_q [$];
	logic [31:0]       i_wdata, o_rdata, st;
	logic [3:0]        bit_cnt;
	int                fails, check_count, cyc, k;

	sfr_link_if lnk ();
	sfr_dev sfr_dev_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_quad_mode(i_quad_mode), .i_load_we(i_load_we),
		.i_load_addr(i_load_addr), .i_load_data(i_load_data), .o_busy(o_busy), .lnk(lnk.dev));
	sfr_host sfr_host_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_quad_mode(i_quad_mode), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .lnk(lnk.host));
	sfr_link_chk sfr_link_chk_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_quad_mode(i_quad_mode),
		.cs_n(lnk.cs_n), .sclk(lnk.sclk), .h_io_oe(lnk.h_io_oe), .d_io_oe(lnk.d_io_oe));

	initial begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end

	task automatic results();
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] want);
		check_count++;
		if (seen !== want) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, want, seen);
		end
	endtask

	// Watches read data, the first line byte of each frame, and the run length.
	always @(posedge i_ref_clk) begin
		cyc++;
		if (rxd_p) check("rx byte", o_rdata[7:0], exp_q.pop_front());
		rxd_p <= i_rd && i_addr == REG_RXD;
		sclk_d <= lnk.sclk;
		if (lnk.cs_n) begin
			bit_cnt <= 4'h0;
		end else if (lnk.sclk && !sclk_d && bit_cnt < 4'h8) begin
			rx_sh = {rx_sh[6:0], lnk.io_i[0]};
			bit_cnt <= bit_cnt + 4'h1;
		end
		if (cyc == 60000) begin
			fails++;
			results();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(negedge i_ref_clk);
		st = o_rdata;
	endtask

	task automatic cmd(input logic [7:0] op, input logic [2:0] al, input logic [4:0] dm, input logic tx,
		input logic q, input logic [7:0] n, input logic [31:0] a, input logic [7:0] d);
		wr(REG_ADDR, a);
		wr(REG_TXD, {24'h0, d});
		wr(REG_CTRL, {1'b1, 3'h0, n, 2'h0, q, tx, dm, al, op});
		for (int i = 0; i < n; i++) begin
			st = 32'h0;
			for (int j = 0; j < 500 && !st[STAT_RXF_BIT]; j++) rd(REG_STAT);
			check("rx ready", {7'h0, st[STAT_RXF_BIT]}, 8'h01);
			rd(REG_RXD);
		end
		st = 32'h1;
		for (int j = 0; j < 500 && st[STAT_BUSY_BIT]; j++) rd(REG_STAT);
		check("host idle", {7'h0, st[STAT_BUSY_BIT]}, 8'h00);
		if (!i_quad_mode) check("opcode on line", rx_sh, op);
	endtask

	task automatic op1(input logic [7:0] op);
		cmd(op, 3'h0, 5'h0, 1'b0, 1'b0, 8'h0, 32'h0, 8'h0);
	endtask

	task automatic rx(input logic [7:0] op, input logic [2:0] al, input logic [4:0] dm, input logic [7:0] n,
		input logic [7:0] e);
		for (int i = 0; i < n; i++) exp_q.push_back(e);
		cmd(op, al, dm, 1'b0, 1'b0, n, 32'h0, 8'h0);
	endtask

	task automatic rdm(input logic [7:0] op, input logic [2:0] al, input logic [4:0] dm, input logic q,
		input logic [7:0] n, input logic [31:0] a);
		for (int i = 0; i < n; i++) exp_q.push_back(mem_m[8'(a[7:0] + i)]);
		cmd(op, al, dm, 1'b0, q, n, a, 8'h0);
	endtask

	initial begin
		{i_srst, i_quad_mode, i_load_we, i_wr, i_rd, rxd_p, sclk_d} = 7'h40;
		{i_load_addr, i_load_data, i_addr, rx_sh, bit_cnt} = '0;
		i_wdata = 32'h0;
		fails = 0;
		check_count = 0;
		cyc = 0;
		k = $urandom(45371);
		repeat (2) @(posedge i_ref_clk);
		i_srst <= 1'b0;
		for (int i = 0; i < 256; i++) begin
			@(posedge i_ref_clk);
			mem_m[i] = 8'($urandom);
			i_load_we <= 1'b1;
			i_load_addr <= 8'(i);
			i_load_data <= mem_m[i];
		end
		@(posedge i_ref_clk);
		i_load_we <= 1'b0;
		rx(OP_STAT_LO_RD, 3'h0, 5'h0, 8'h1, 8'h00);
		rx(OP_STAT_HI_RD, 3'h0, 5'h0, 8'h1, 8'h00);
		rx(OP_UPPER_RD, 3'h0, 5'h0, 8'h1, UPPER_RST);
		r = {1'b1, 6'($urandom), 1'b0};
		cmd(OP_UPPER_WR, 3'h0, 5'h0, 1'b1, 1'b0, 8'h0, 32'h0, r);
		rx(OP_UPPER_RD, 3'h0, 5'h0, 8'h1, UPPER_RST);
		op1(OP_WRITE_UNLOCK);
		rx(OP_STAT_LO_RD, 3'h0, 5'h0, 8'h1, 8'h02);
		cmd(OP_UPPER_WR, 3'h0, 5'h0, 1'b1, 1'b0, 8'h0, 32'h0, r);
		rx(OP_UPPER_RD, 3'h0, 5'h0, 8'h2, r);
		rdm(OP_READ, 3'h3, 5'h0, 1'b0, 8'h3, 32'($urandom_range(255)) | 32'h00ab0000);
		rdm(OP_FAST, 3'h3, 5'(FAST_DUMMY_CLKS), 1'b0, 8'h3, 32'h0000fe);
		rdm(OP_QOUT, 3'h3, 5'(FAST_DUMMY_CLKS), 1'b1, 8'h2, 32'($urandom_range(255)));
		rdm(OP_READ_4B, 3'h4, 5'h0, 1'b0, 8'h1, {8'h3c, 16'h0, 8'($urandom)});
		rdm(OP_QOUT_4B, 3'h4, 5'(FAST_DUMMY_CLKS), 1'b1, 8'h2, 32'($urandom));
		op1(OP_WRITE_UNLOCK);
		op1(OP_WRITE_LOCK);
		rx(OP_STAT_LO_RD, 3'h0, 5'h0, 8'h1, 8'h00);
		// Frame closes before the data byte, so the write must be dropped.
		op1(OP_WRITE_UNLOCK);
		cmd(OP_NVCFG_WR, 3'h3, 5'h0, 1'b0, 1'b0, 8'h0, 32'h0, r);
		rx(OP_STAT_LO_RD, 3'h0, 5'h0, 8'h1, 8'h02);
		for (int i = 0; i < 4; i++) begin
			op1(OP_WRITE_UNLOCK);
			cmd(i == 3 ? OP_VCFG_WR : OP_NVCFG_WR, 3'h3, 5'h0, 1'b1, 1'b0, 8'h0, 32'h0, r);
			if (i == 0) rx(OP_STAT_LO_RD, 3'h0, 5'h0, 8'h1, 8'h03);
			if (i == 0) check("busy pin", {7'h0, o_busy}, 8'h01);
			if (i == 1) rx(OP_READ, 3'h3, 5'h0, 8'h1, 8'hff);
			if (i == 2) rx(OP_NVCFG_RD, 3'h3, 5'(CFG_DUMMY_BITS), 8'h1, 8'hff);
			for (k = 0; k < 1000 && o_busy !== 1'b0; k++) @(posedge i_ref_clk);
			check("busy end", {7'h0, o_busy}, 8'h00);
			rx(OP_STAT_LO_RD, 3'h0, 5'h0, 8'h1, 8'h00);
		end
		rx(OP_NVCFG_RD, 3'h3, 5'(CFG_DUMMY_BITS), 8'h1, r);
		rx(OP_VCFG_RD, 3'h3, 5'(CFG_DUMMY_BITS), 8'h1, r);
		op1(OP_ENTER_4B);
		rx(OP_STAT_HI_RD, 3'h0, 5'h0, 8'h1, 8'h01);
		u = r ^ 8'h5a;
		rdm(OP_READ, 3'h4, 5'h0, 1'b0, 8'h1, {u, 16'h0, 8'($urandom)});
		rx(OP_UPPER_RD, 3'h0, 5'h0, 8'h1, u);
		op1(OP_EXIT_4B);
		rx(OP_UPPER_RD, 3'h0, 5'h0, 8'h1, u);
		rx(OP_STAT_HI_RD, 3'h0, 5'h0, 8'h1, 8'h00);
		@(posedge i_ref_clk);
		i_quad_mode <= 1'b1;
		rx(OP_UPPER_RD, 3'h0, 5'h0, 8'h1, u);
		rx(OP_STAT_LO_RD, 3'h0, 5'h0, 8'h1, 8'h00);
		rdm(OP_FAST, 3'h3, 5'(FAST_DUMMY_CLKS), 1'b0, 8'h2, 32'($urandom_range(255)));
		@(posedge i_ref_clk);
		i_quad_mode <= 1'b0;
		results();
	end
endmodule // serial_flash_reg_and_read_cmds_bench
